/* common/dotr_defines.svh */
// What this block does
// - A rising capture clock edge stores that half's data inputs; outputs follow.
// - Two independent 8-bit halves, each with own clock and output enable.
// - Outputs present stored bits uninverted and can float besides driving.
// - Output enable is active low: low drives, high releases the outputs.
// - Enabled half with a rising edge shows the loaded levels from the first core clock edge after the rise.
// - Without a rising edge a half keeps stored value and output state.
// - Enable high puts all eight outputs of that half in high impedance.
// - Edges still load while disabled; re-enabling shows the new value.
`ifndef DOTR_DEFINES_SVH
`define DOTR_DEFINES_SVH

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define DOTR_HALF_W       8
`define DOTR_WORD_W       16
`define DOTR_STORE_RST    8'h00
`define DOTR_DRIVE_N_RST  1'b1
`define DOTR_BUF_DEPTH    2'h2

`endif

/* common/dotr_pkg.sv */
`include "dotr_defines.svh"

package dotr_pkg;

  // ****************************************************************
  // Capture record
  // ****************************************************************
  typedef struct packed {
    logic                      high_loaded;
    logic                      low_loaded;
    logic [`DOTR_WORD_W-1:0]   word;
  } dotr_cap_s;

  typedef enum logic [1:0] {
    DOTR_EMPTY,
    DOTR_ONE,
    DOTR_TWO
  } dotr_fill_e;

endpackage

/* core/dotr_buffer.sv */
`include "dotr_defines.svh"

module dotr_buffer (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              in_valid_in,
  input  dotr_pkg::dotr_cap_s    in_data_in,
  output logic                   in_ready_out,
  output logic                   out_valid_out,
  input  wire logic              out_ready_in,
  output dotr_pkg::dotr_cap_s    out_data_out
);

  // ****************************************************************
  // Two-entry store
  // ****************************************************************
  dotr_pkg::dotr_fill_e fill_reg;
  dotr_pkg::dotr_fill_e fill_next;
  dotr_pkg::dotr_cap_s  head_reg;
  dotr_pkg::dotr_cap_s  tail_reg;
  logic                 push;
  logic                 pop;

  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  always_comb begin
    fill_next = fill_reg;
    case (fill_reg)
      dotr_pkg::DOTR_EMPTY: if (push) fill_next = dotr_pkg::DOTR_ONE;
      dotr_pkg::DOTR_ONE: begin
        if (push && !pop) fill_next = dotr_pkg::DOTR_TWO;
        else if (pop && !push) fill_next = dotr_pkg::DOTR_EMPTY;
      end
      dotr_pkg::DOTR_TWO: if (pop) fill_next = dotr_pkg::DOTR_ONE;
      default: fill_next = dotr_pkg::DOTR_EMPTY;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fill_reg      <= dotr_pkg::DOTR_EMPTY;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      fill_reg      <= fill_next;
      in_ready_out  <= (fill_next != dotr_pkg::DOTR_TWO);
      out_valid_out <= (fill_next != dotr_pkg::DOTR_EMPTY);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      head_reg <= '0;
      tail_reg <= '0;
    end else begin
      if (fill_reg == dotr_pkg::DOTR_TWO && pop) begin
        head_reg <= tail_reg;
      end else if (push && (fill_reg == dotr_pkg::DOTR_EMPTY || pop)) begin
        head_reg <= in_data_in;
      end
      if (push && fill_reg == dotr_pkg::DOTR_ONE && !pop) begin
        tail_reg <= in_data_in;
      end
    end
  end

  assign out_data_out = head_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_no_overflow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (fill_reg == dotr_pkg::DOTR_TWO) |-> !in_ready_out)
    else $error("buffer full but ready");
  a_hold_stall: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (out_valid_out && !out_ready_in) |=> (out_valid_out && $stable(out_data_out)))
    else $error("stalled word changed");

endmodule

/* core/dotr_top.sv */
`include "dotr_defines.svh"

module dotr_top (
  input  wire logic                    core_clk_in,
  input  wire logic                    arst_n_in,
  input  wire logic                    low_half_capture_clock_in,
  input  wire logic                    high_half_capture_clock_in,
  input  wire logic                    low_half_out_en_low_in,
  input  wire logic                    high_half_out_en_low_in,
  input  wire logic [`DOTR_HALF_W-1:0] low_half_data_in_bits_in,
  input  wire logic [`DOTR_HALF_W-1:0] high_half_data_in_bits_in,
  output logic      [`DOTR_HALF_W-1:0] low_half_data_out_bits_out,
  output logic      [`DOTR_HALF_W-1:0] high_half_data_out_bits_out,
  output logic                         low_half_drive_n_out,
  output logic                         high_half_drive_n_out,
  output logic                         cap_ready_out,
  output logic                         cap_valid_out,
  input  wire logic                    cap_ready_in,
  output dotr_pkg::dotr_cap_s          cap_data_out
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic edge_up(input logic now_lvl,
                                   input logic was_lvl);
    return now_lvl & ~was_lvl;
  endfunction

  function automatic logic [`DOTR_HALF_W-1:0] pick_half(
    input logic                    fresh_sel,
    input logic [`DOTR_HALF_W-1:0] fresh_val,
    input logic [`DOTR_HALF_W-1:0] kept_val
  );
    return fresh_sel ? fresh_val : kept_val;
  endfunction

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // Capture clock edge detect
  // ****************************************************************
  logic low_clk_prev_reg;
  logic high_clk_prev_reg;
  logic low_rise;
  logic high_rise;

  always_ff @(posedge core_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      low_clk_prev_reg  <= 1'b1;
      high_clk_prev_reg <= 1'b1;
    end else begin
      low_clk_prev_reg  <= low_half_capture_clock_in;
      high_clk_prev_reg <= high_half_capture_clock_in;
    end
  end

  assign low_rise  = edge_up(low_half_capture_clock_in, low_clk_prev_reg);
  assign high_rise = edge_up(high_half_capture_clock_in, high_clk_prev_reg);

  // ****************************************************************
  // Storage, one register per half
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      low_half_data_out_bits_out <= `DOTR_STORE_RST;
    end else if (low_rise) begin
      low_half_data_out_bits_out <= low_half_data_in_bits_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      high_half_data_out_bits_out <= `DOTR_STORE_RST;
    end else if (high_rise) begin
      high_half_data_out_bits_out <= high_half_data_in_bits_in;
    end
  end

  // ****************************************************************
  // Output drive enables, low while driving
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      low_half_drive_n_out  <= `DOTR_DRIVE_N_RST;
      high_half_drive_n_out <= `DOTR_DRIVE_N_RST;
    end else begin
      low_half_drive_n_out  <= low_half_out_en_low_in;
      high_half_drive_n_out <= high_half_out_en_low_in;
    end
  end

  // ****************************************************************
  // Capture record stream
  // ****************************************************************
  dotr_pkg::dotr_cap_s cap_rec;
  logic                cap_push;

  assign cap_push             = low_rise | high_rise;
  assign cap_rec.low_loaded   = low_rise;
  assign cap_rec.high_loaded  = high_rise;
  assign cap_rec.word         = {pick_half(high_rise, high_half_data_in_bits_in,
                                           high_half_data_out_bits_out),
                                 pick_half(low_rise, low_half_data_in_bits_in,
                                           low_half_data_out_bits_out)};

  dotr_buffer u_buffer (
    .clk_in        (core_clk_in),
    .rst_n_in      (rst_n_reg),
    .in_valid_in   (cap_push),
    .in_data_in    (cap_rec),
    .in_ready_out  (cap_ready_out),
    .out_valid_out (cap_valid_out),
    .out_ready_in  (cap_ready_in),
    .out_data_out  (cap_data_out)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_low_load: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    low_rise |=> low_half_data_out_bits_out == $past(low_half_data_in_bits_in))
    else $error("low half did not load");
  a_high_load: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    high_rise |=> high_half_data_out_bits_out == $past(high_half_data_in_bits_in))
    else $error("high half did not load");
  a_no_invert: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    low_rise |=> (low_half_data_out_bits_out ^ $past(low_half_data_in_bits_in)) == 8'h00)
    else $error("output inverted");
  a_enable_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    !low_half_out_en_low_in |=> !low_half_drive_n_out)
    else $error("enable low did not drive");
  a_load_shown: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    (low_rise && !low_half_out_en_low_in) |=>
      (!low_half_drive_n_out && low_half_data_out_bits_out == $past(low_half_data_in_bits_in)))
    else $error("enabled load not shown");
  a_hold_value: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    (!low_rise && !high_rise) |=> ($stable(low_half_data_out_bits_out)
      && $stable(high_half_data_out_bits_out)))
    else $error("value changed without edge");
  a_float_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    high_half_out_en_low_in |=> high_half_drive_n_out)
    else $error("disabled half still driving");
  a_load_while_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    (low_rise && low_half_out_en_low_in) ##1 (!low_rise && !low_half_out_en_low_in) |=>
      (!low_half_drive_n_out
       && low_half_data_out_bits_out == $past(low_half_data_in_bits_in, 2)))
    else $error("hidden load lost");
  a_reset_state: assert property (@(posedge core_clk_in)
    $rose(rst_n_reg) |-> (low_half_data_out_bits_out == 8'h00
      && high_half_data_out_bits_out == 8'h00 && low_half_drive_n_out
      && high_half_drive_n_out))
    else $error("reset state wrong");

  // ****************************************************************
  // Checks, high half and low float
  // ****************************************************************
  a_high_no_invert: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    high_rise |=> (high_half_data_out_bits_out ^ $past(high_half_data_in_bits_in)) == 8'h00)
    else $error("high output inverted");

  a_high_en_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    !high_half_out_en_low_in |=> !high_half_drive_n_out)
    else $error("high enable low did not drive");

  a_high_load_shown: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    (high_rise && !high_half_out_en_low_in) |=>
      (!high_half_drive_n_out
       && high_half_data_out_bits_out == $past(high_half_data_in_bits_in)))
    else $error("enabled high load not shown");

  a_low_float_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    low_half_out_en_low_in |=> low_half_drive_n_out)
    else $error("disabled low half still driving");

  // ****************************************************************
  // Checks, capture record stream
  // ****************************************************************
  a_record_push: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    (cap_push && cap_ready_out) |=> cap_valid_out)
    else $error("pushed record not offered");

  a_record_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    (low_rise && !high_rise && cap_ready_out && !cap_valid_out) |=>
      (cap_data_out.low_loaded && !cap_data_out.high_loaded
       && cap_data_out.word[7:0] == low_half_data_out_bits_out
       && cap_data_out.word[15:8] == high_half_data_out_bits_out))
    else $error("record does not match stored word");

  a_full_holds: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    (!cap_ready_out && !cap_ready_in) |=> !cap_ready_out)
    else $error("full buffer freed without a pop");

  a_pop_frees: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    (!cap_ready_out && cap_ready_in) |=> cap_ready_out)
    else $error("drained buffer stays full");

  // ****************************************************************
  // Coverage
  // ****************************************************************
  c_low_load: cover property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    low_rise && !low_half_out_en_low_in);
  c_hidden_load: cover property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    low_rise && low_half_out_en_low_in);
  c_both_load: cover property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    low_rise && high_rise);
  c_buffer_full: cover property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    !cap_ready_out);
  c_record_drop: cover property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    cap_push && !cap_ready_out);

endmodule

/* tb/dotr_bus_driver.sv */
module dotr_bus_driver (
  input  wire logic       clk_in,
  output logic            low_clk_out,
  output logic            high_clk_out,
  output logic [7:0]      low_data_out,
  output logic [7:0]      high_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Upstream bus logic: data, then a clock rise, then release
  // ****************************************************************
  initial begin
    low_clk_out   = 1'b0;
    high_clk_out  = 1'b0;
    low_data_out  = 8'h00;
    high_data_out = 8'h00;
  end

  task automatic load(input logic lo, input logic hi, input logic [7:0] dl,
                      input logic [7:0] dh);
    @(negedge clk_in);
    if (lo) low_data_out = dl;
    if (hi) high_data_out = dh;
    @(negedge clk_in);
    low_clk_out  = lo;
    high_clk_out = hi;
    @(negedge clk_in);
    low_clk_out   = 1'b0;
    high_clk_out  = 1'b0;
    low_data_out  = ~low_data_out;
    high_data_out = ~high_data_out;
  endtask
endmodule

/* tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals, clock, instances
  // ****************************************************************
  logic                clk;
  logic                arst_n;
  logic                low_en_n;
  logic                high_en_n;
  logic                sink_ready;
  logic                low_cclk;
  logic                high_cclk;
  logic [7:0]          low_d;
  logic [7:0]          high_d;
  logic [7:0]          low_q;
  logic [7:0]          high_q;
  logic                low_drv_n;
  logic                high_drv_n;
  logic                cap_rdy;
  logic                cap_vld;
  dotr_pkg::dotr_cap_s cap_data;
  wire  [7:0]          low_bus  = low_drv_n ? 8'hZZ : low_q;
  wire  [7:0]          high_bus = high_drv_n ? 8'hZZ : high_q;
  int                  err_count;
  int                  check_count;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  dotr_bus_driver dotr_bus_driver_i (.clk_in(clk), .low_clk_out(low_cclk),
    .high_clk_out(high_cclk), .low_data_out(low_d), .high_data_out(high_d));

  dotr_top dotr_top_i (.core_clk_in(clk), .arst_n_in(arst_n),
    .low_half_capture_clock_in(low_cclk), .high_half_capture_clock_in(high_cclk),
    .low_half_out_en_low_in(low_en_n), .high_half_out_en_low_in(high_en_n),
    .low_half_data_in_bits_in(low_d), .high_half_data_in_bits_in(high_d),
    .low_half_data_out_bits_out(low_q), .high_half_data_out_bits_out(high_q),
    .low_half_drive_n_out(low_drv_n), .high_half_drive_n_out(high_drv_n),
    .cap_ready_out(cap_rdy), .cap_valid_out(cap_vld), .cap_ready_in(sink_ready),
    .cap_data_out(cap_data));

  // ****************************************************************
  // Shared tasks and scenarios
  // ****************************************************************
  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      err_count++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic t_reset();
    chk({10'h000, low_q}, 18'h00000, "low cleared");
    chk({10'h000, high_q}, 18'h00000, "high cleared");
    chk({10'h000, low_bus}, {10'h000, 8'hZZ}, "low float");
    chk({17'h00000, high_drv_n}, 18'h00001, "high released");
    $display("test reset done");
  endtask

  task automatic t_load_both();
    sink_ready = 1'b0;
    low_en_n   = 1'b0;
    high_en_n  = 1'b0;
    dotr_bus_driver_i.load(1'b1, 1'b1, 8'hA5, 8'h3C);
    chk({10'h000, low_bus}, 18'h000A5, "low bus");
    chk({10'h000, high_bus}, 18'h0003C, "high bus");
    chk({17'h00000, low_drv_n}, 18'h00000, "low driving");
    @(negedge clk);
    chk({17'h00000, cap_vld}, 18'h00001, "record valid");
    chk(cap_data, 18'h33CA5, "record word");
    sink_ready = 1'b1;
    @(negedge clk);
    chk({17'h00000, cap_vld}, 18'h00000, "record taken");
    $display("test load both done");
  endtask

  task automatic t_hold();
    dotr_bus_driver_i.load(1'b1, 1'b0, 8'h96, 8'h00);
    chk({10'h000, low_q}, 18'h00096, "low loaded");
    repeat (4) @(negedge clk);
    chk({10'h000, high_bus}, 18'h0003C, "high kept");
    chk({10'h000, low_bus}, 18'h00096, "low kept");
    $display("test hold done");
  endtask

  task automatic t_disabled();
    low_en_n = 1'b1;
    @(negedge clk);
    chk({10'h000, low_bus}, {10'h000, 8'hZZ}, "low off");
    chk({10'h000, high_bus}, 18'h0003C, "high still on");
    dotr_bus_driver_i.load(1'b1, 1'b0, 8'h5A, 8'h00);
    chk({10'h000, low_bus}, {10'h000, 8'hZZ}, "low off");
    low_en_n = 1'b0;
    @(negedge clk);
    chk({10'h000, low_bus}, 18'h0005A, "new value shown");
    $display("test disabled load done");
  endtask

  task automatic t_buffer();
    sink_ready = 1'b0;
    dotr_bus_driver_i.load(1'b1, 1'b0, 8'h11, 8'h00);
    dotr_bus_driver_i.load(1'b1, 1'b0, 8'h22, 8'h00);
    chk({17'h00000, cap_rdy}, 18'h00000, "buffer full");
    dotr_bus_driver_i.load(1'b1, 1'b0, 8'h33, 8'h00);
    chk({10'h000, low_bus}, 18'h00033, "loads while full");
    chk(cap_data, 18'h13C11, "first record");
    sink_ready = 1'b1;
    @(negedge clk);
    sink_ready = 1'b0;
    chk(cap_data, 18'h13C22, "second record");
    sink_ready = 1'b1;
    @(negedge clk);
    chk({16'h0000, cap_vld, cap_rdy}, 18'h00001, "drained");
    $display("test buffer done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    err_count   = 0;
    check_count = 0;
    arst_n      = 1'b0;
    low_en_n    = 1'b1;
    high_en_n   = 1'b1;
    sink_ready  = 1'b1;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_load_both();
    t_hold();
    t_disabled();
    t_buffer();
    summarize();
  end

  initial begin
    #40000;
    err_count++;
    summarize();
  end
endmodule
